// ### verilog/serial_ctl_pkg.sv
// constants and types of the serial module global control block
package serial_ctl_pkg;

	// ----------------------------------------------------------------
	// register word indices
	// ----------------------------------------------------------------
	localparam logic [1:0] CFG_IDX = 2'h0;
	localparam logic [1:0] LVL_VEC_IDX = 2'h1;

	// ----------------------------------------------------------------
	// module configuration fields
	// ----------------------------------------------------------------
	localparam int STOP_BIT = 15;
	localparam int FRZ1_BIT = 14;
	localparam int FRZ0_BIT = 13;
	localparam int ARB_NUM_LSB = 0;
	localparam int ARB_NUM_W = 4;
	localparam logic [15:0] CFG_RESET = 16'h8000;
	localparam logic [15:0] CFG_MASK = 16'hE00F;

	// ----------------------------------------------------------------
	// interrupt level and vector fields
	// ----------------------------------------------------------------
	localparam int SYNC_LVL_LSB = 3;
	localparam int ASYNC_LVL_LSB = 0;
	localparam int LVL_W = 3;
	localparam logic [7:0] LVL_RESET = 8'h00;
	localparam logic [7:0] LVL_MASK = 8'h3F;
	localparam logic [7:0] VEC_RESET = 8'h0F;
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic VEC_BIT0_READ = 1'b1;
	localparam logic SRC_SYNC = 1'b1;
	localparam logic SRC_ASYNC = 1'b0;
	localparam logic [15:0] RDATA_ZERO = 16'h0000;

	// ----------------------------------------------------------------
	// serial arbitration
	// ----------------------------------------------------------------
	localparam logic [1:0] ARB_MSB_IDX = 2'h3;
	localparam logic [1:0] ARB_LSB_IDX = 2'h0;
	localparam logic [1:0] ARB_IDX_STEP = 2'h1;
	localparam logic [3:0] ARB_NUM_NONE = 4'h0;

	typedef enum logic [0:0] {
		ARB_IDLE,
		ARB_BIT
	} arb_state_t;

endpackage

// ### verilog/arb_contender.sv
// serial arbitration number contention on a wired-or line
`timescale 1ns/10ps
module arb_contender (
	// clock and control
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// request
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic [3:0] arb_num_i,
	// wired-or line
	input wire logic line_i,
	output logic line_o,
	output logic line_oe_o,
	// result
	output logic won_o
);

	serial_ctl_pkg::arb_state_t st_q, st_d;
	logic [1:0] idx_q, idx_d;
	logic drv_q, drv_d;
	logic won_q, won_d;

	// ----------------------------------------------------------------
	// bit-serial contention, msb first
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		idx_d = idx_q;
		drv_d = 1'b0;
		won_d = 1'b0;
		unique case (st_q)
			serial_ctl_pkg::ARB_IDLE:
			begin
				if (start_i)
				begin
					st_d = serial_ctl_pkg::ARB_BIT;
					idx_d = serial_ctl_pkg::ARB_MSB_IDX;
					drv_d = arb_num_i[serial_ctl_pkg::ARB_MSB_IDX];
				end
			end
			serial_ctl_pkg::ARB_BIT:
			begin
				// a one seen while driving zero means a higher number
				if (abort_i || (!drv_q && line_i))
				begin
					st_d = serial_ctl_pkg::ARB_IDLE;
				end
				else if (idx_q == serial_ctl_pkg::ARB_LSB_IDX)
				begin
					st_d = serial_ctl_pkg::ARB_IDLE;
					won_d = 1'b1;
				end
				else
				begin
					idx_d = idx_q - serial_ctl_pkg::ARB_IDX_STEP;
					drv_d = arb_num_i[idx_d];
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			st_q <= serial_ctl_pkg::ARB_IDLE;
			idx_q <= serial_ctl_pkg::ARB_MSB_IDX;
			drv_q <= 1'b0;
			won_q <= 1'b0;
		end
		else if (ce_i)
		begin
			st_q <= st_d;
			idx_q <= idx_d;
			drv_q <= drv_d;
			won_q <= won_d;
		end
	end

	assign line_o = drv_q;
	assign line_oe_o = drv_q;
	assign won_o = won_q;

endmodule

// ### verilog/serial_global_ctl.sv
// global control of the queued serial unit: stop, freeze, interrupts
`timescale 1ns/10ps
module serial_global_ctl (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// register port
	input wire logic [1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [1:0] reg_be_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_ack_o,
	// low-power stop
	output logic module_clk_en_o,
	output logic ram_read_en_o,
	// freeze
	input wire logic freeze_i,
	input wire logic sync_boundary_i,
	output logic sync_halt_o,
	// submodule requests and request lines
	input wire logic sync_irq_i,
	input wire logic async_irq_i,
	output logic [7:1] irq_lines_o,
	// interrupt acknowledge
	input wire logic iack_i,
	input wire logic [2:0] iack_mask_i,
	input wire logic arb_line_i,
	output logic arb_line_o,
	output logic arb_line_oe_o,
	output logic [7:0] vec_o,
	output logic vec_oe_o
);

	logic [15:0] cfg_q, cfg_d;
	logic [7:0] lvl_q, lvl_d;
	logic [7:0] vector_q, vector_d;
	logic [15:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic clk_en_q, clk_en_d;
	logic ram_rd_q, ram_rd_d;
	logic halt_q, halt_d;
	logic [7:1] irq_q, irq_d;
	logic iack_q, iack_d;
	logic src_q, src_d;
	logic [7:0] vec_out_q, vec_out_d;
	logic vec_oe_q, vec_oe_d;
	logic [2:0] sync_lvl, async_lvl, sync_eff, async_eff, pend_lvl;
	logic sync_wins;
	logic [3:0] arb_num;
	logic start;
	logic won;

	// ----------------------------------------------------------------
	// registers, stop and freeze
	// ----------------------------------------------------------------
	always_comb
	begin
		cfg_d = cfg_q;
		lvl_d = lvl_q;
		vector_d = vector_q;
		rdata_d = serial_ctl_pkg::RDATA_ZERO;
		ack_d = reg_wr_i | reg_rd_i;
		halt_d = halt_q;
		// writes are taken whether stopped or not
		if (reg_wr_i)
		begin
			if (reg_addr_i == serial_ctl_pkg::CFG_IDX)
			begin
				// setting stop by software
				if (reg_be_i[1])
					cfg_d[15:8] = reg_wdata_i[15:8]
						& serial_ctl_pkg::CFG_MASK[15:8];
				if (reg_be_i[0])
					cfg_d[7:0] = reg_wdata_i[7:0]
						& serial_ctl_pkg::CFG_MASK[7:0];
			end
			else if (reg_addr_i == serial_ctl_pkg::LVL_VEC_IDX)
			begin
				if (reg_be_i[1])
					lvl_d = reg_wdata_i[15:8]
						& serial_ctl_pkg::LVL_MASK;
				// bit0 of the vector is not writable
				if (reg_be_i[0])
					vector_d = {reg_wdata_i[7:1],
						serial_ctl_pkg::VEC_BIT0_READ};
			end
		end
		if (reg_rd_i)
		begin
			if (reg_addr_i == serial_ctl_pkg::CFG_IDX)
				rdata_d = cfg_q;
			else if (reg_addr_i == serial_ctl_pkg::LVL_VEC_IDX
				&& !cfg_q[serial_ctl_pkg::STOP_BIT])
				rdata_d = {lvl_q, vector_q};
		end
		clk_en_d = !cfg_d[serial_ctl_pkg::STOP_BIT];
		ram_rd_d = !cfg_d[serial_ctl_pkg::STOP_BIT];
		// halt at a transfer boundary; freeze bit zero is unused
		if (!freeze_i)
			halt_d = 1'b0;
		else if (cfg_q[serial_ctl_pkg::FRZ1_BIT] && sync_boundary_i)
			halt_d = 1'b1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			cfg_q <= serial_ctl_pkg::CFG_RESET;
			lvl_q <= serial_ctl_pkg::LVL_RESET;
			vector_q <= serial_ctl_pkg::VEC_RESET;
			rdata_q <= serial_ctl_pkg::RDATA_ZERO;
			ack_q <= 1'b0;
			clk_en_q <= 1'b0;
			ram_rd_q <= 1'b0;
			halt_q <= 1'b0;
		end
		else if (ce_i)
		begin
			cfg_q <= cfg_d;
			lvl_q <= lvl_d;
			vector_q <= vector_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			clk_en_q <= clk_en_d;
			ram_rd_q <= ram_rd_d;
			halt_q <= halt_d;
		end
	end

	// ----------------------------------------------------------------
	// request lines and pending level
	// ----------------------------------------------------------------
	always_comb
	begin
		// two separate fields, one shared vector
		sync_lvl = lvl_q[serial_ctl_pkg::SYNC_LVL_LSB
			+: serial_ctl_pkg::LVL_W];
		async_lvl = lvl_q[serial_ctl_pkg::ASYNC_LVL_LSB
			+: serial_ctl_pkg::LVL_W];
		// requests follow the submodule levels until cleared there
		sync_eff = sync_irq_i ? sync_lvl : serial_ctl_pkg::LVL_NONE;
		async_eff = async_irq_i ? async_lvl : serial_ctl_pkg::LVL_NONE;
		sync_wins = (sync_eff != serial_ctl_pkg::LVL_NONE)
			&& (sync_eff >= async_eff);
		pend_lvl = sync_wins ? sync_eff : async_eff;
		irq_d = '0;
		for (int i = 1; i <= 7; i++)
		begin
			// level zero matches no line
			irq_d[i] = (sync_eff == 3'(i)) || (async_eff == 3'(i));
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			irq_q <= '0;
		else if (ce_i)
			irq_q <= irq_d;
	end

	// ----------------------------------------------------------------
	// acknowledge, arbitration and vector
	// ----------------------------------------------------------------
	assign arb_num = cfg_q[serial_ctl_pkg::ARB_NUM_LSB
		+: serial_ctl_pkg::ARB_NUM_W];

	always_comb
	begin
		iack_d = iack_i;
		src_d = src_q;
		vec_out_d = vec_out_q;
		vec_oe_d = vec_oe_q;
		start = iack_i && !iack_q
			&& pend_lvl != serial_ctl_pkg::LVL_NONE
			&& iack_mask_i == pend_lvl
			&& arb_num != serial_ctl_pkg::ARB_NUM_NONE;
		if (start)
			src_d = sync_wins ? serial_ctl_pkg::SRC_SYNC
				: serial_ctl_pkg::SRC_ASYNC;
		if (!iack_i)
		begin
			vec_oe_d = 1'b0;
			vec_out_d = '0;
		end
		else if (won)
		begin
			vec_oe_d = 1'b1;
			vec_out_d = {vector_q[7:1], src_q};
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			iack_q <= 1'b0;
			src_q <= serial_ctl_pkg::SRC_ASYNC;
			vec_out_q <= '0;
			vec_oe_q <= 1'b0;
		end
		else if (ce_i)
		begin
			iack_q <= iack_d;
			src_q <= src_d;
			vec_out_q <= vec_out_d;
			vec_oe_q <= vec_oe_d;
		end
	end

	arb_contender u_arb (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.start_i(start),
		.abort_i(!iack_i),
		.arb_num_i(arb_num),
		.line_i(arb_line_i),
		.line_o(arb_line_o),
		.line_oe_o(arb_line_oe_o),
		.won_o(won)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o = rdata_q;
	assign reg_ack_o = ack_q;
	assign module_clk_en_o = clk_en_q;
	assign ram_read_en_o = ram_rd_q;
	assign sync_halt_o = halt_q;
	assign irq_lines_o = irq_q;
	assign vec_o = vec_out_q;
	assign vec_oe_o = vec_oe_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	a_stop_gates_clk: assert property (
		ce_i && reg_wr_i && reg_addr_i == serial_ctl_pkg::CFG_IDX
		&& reg_be_i[1] && reg_wdata_i[serial_ctl_pkg::STOP_BIT]
		|=> !module_clk_en_o && !ram_read_en_o)
		else $error("stop write did not gate clock");

	a_stop_read_zero: assert property (
		ce_i && reg_rd_i && reg_addr_i == serial_ctl_pkg::LVL_VEC_IDX
		&& cfg_q[serial_ctl_pkg::STOP_BIT]
		|=> reg_ack_o && reg_rdata_o == serial_ctl_pkg::RDATA_ZERO)
		else $error("level word readable during stop");

	a_stop_write_ok: assert property (
		ce_i && !reg_rd_i && reg_wr_i
		&& reg_addr_i == serial_ctl_pkg::LVL_VEC_IDX && reg_be_i[1]
		&& cfg_q[serial_ctl_pkg::STOP_BIT]
		|=> lvl_q == ($past(reg_wdata_i[15:8]) & serial_ctl_pkg::LVL_MASK))
		else $error("write lost during stop");

	a_reset_values: assert property (
		$past(rst_i) |-> cfg_q[serial_ctl_pkg::STOP_BIT]
		&& vector_q == serial_ctl_pkg::VEC_RESET && !module_clk_en_o)
		else $error("wrong state after reset");

	a_freeze_halt: assert property (
		ce_i && freeze_i && cfg_q[serial_ctl_pkg::FRZ1_BIT]
		&& sync_boundary_i ##1 ce_i && freeze_i |=> sync_halt_o)
		else $error("no halt on freeze");

	a_freeze_off: assert property (
		ce_i && !cfg_q[serial_ctl_pkg::FRZ1_BIT] && !halt_q
		|=> !sync_halt_o)
		else $error("halt without freeze bit one");

	a_level_line: assert property (
		ce_i && sync_irq_i && sync_lvl != serial_ctl_pkg::LVL_NONE
		|=> irq_lines_o[$past(sync_lvl)])
		else $error("sync request on wrong line");

	a_level_zero: assert property (
		ce_i && (!sync_irq_i || sync_lvl == serial_ctl_pkg::LVL_NONE)
		&& (!async_irq_i || async_lvl == serial_ctl_pkg::LVL_NONE)
		|=> irq_lines_o == '0)
		else $error("request with level zero");

	a_mask_match: assert property (
		ce_i && iack_i && !iack_q && iack_mask_i != pend_lvl
		|=> !arb_line_oe_o)
		else $error("contended on mismatched mask");

	a_zero_arb: assert property (
		arb_num == serial_ctl_pkg::ARB_NUM_NONE && !arb_line_oe_o
		|=> !arb_line_oe_o)
		else $error("contended with zero number");

	a_zero_no_start: assert property (
		arb_num == serial_ctl_pkg::ARB_NUM_NONE |-> !start)
		else $error("arbitration started with zero number");

	a_vector_drive: assert property (
		vec_oe_o |-> vec_o[7:1] == vector_q[7:1] && vec_o[0] == src_q)
		else $error("bad vector driven");

	a_vec_bit0: assert property (
		ce_i && reg_rd_i && reg_addr_i == serial_ctl_pkg::LVL_VEC_IDX
		&& !cfg_q[serial_ctl_pkg::STOP_BIT] |=> reg_rdata_o[0])
		else $error("vector bit0 read as zero");

	a_sync_first: assert property (
		ce_i && sync_irq_i && async_irq_i && sync_lvl == async_lvl
		&& sync_lvl != serial_ctl_pkg::LVL_NONE |-> sync_wins)
		else $error("async served before sync");

	c_stop_entry: cover property (
		module_clk_en_o ##1 !module_clk_en_o);
	c_vector_won: cover property (
		iack_i && !iack_q ##[1:8] vec_oe_o);
	c_freeze_halt: cover property (
		!sync_halt_o ##1 sync_halt_o);
	c_both_pending: cover property (
		sync_irq_i && async_irq_i && sync_wins);

endmodule

// ### bench/core_bus_model.sv
// processor core model: register access, acknowledge, rival contender
`timescale 1ns/10ps
module core_bus_model (
	// clock
	input wire logic core_clk_i,
	// register port
	output logic [1:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [1:0] reg_be_o,
	output logic [15:0] reg_wdata_o,
	input wire logic [15:0] reg_rdata_i,
	input wire logic reg_ack_i,
	// acknowledge and rival module
	output logic iack_o,
	output logic [2:0] iack_mask_o,
	output logic rival_o,
	input wire logic arb_oe_i,
	input wire logic [7:0] vec_i,
	input wire logic vec_oe_i
);
	initial
	begin
		reg_addr_o = 2'h0;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_be_o = 2'h0;
		reg_wdata_o = 16'h0000;
		iack_o = 1'b0;
		iack_mask_o = 3'h0;
		rival_o = 1'b0;
	end

	// one strobe cycle, answer taken one edge later
	task automatic access(input logic wr, input logic [1:0] addr,
		input logic [1:0] be, input logic [15:0] wdata,
		output logic [15:0] rdata, output logic ack);
		@(posedge core_clk_i);
		#1;
		reg_wr_o = wr;
		reg_rd_o = ~wr;
		reg_addr_o = addr;
		reg_be_o = be;
		reg_wdata_o = wdata;
		@(posedge core_clk_i);
		#1;
		ack = reg_ack_i;
		rdata = reg_rdata_i;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		// released bus shows no stale value
		reg_addr_o = ~addr;
		reg_wdata_o = ~wdata;
	endtask

	// acknowledge cycle; rival drives ones as a higher number
	task automatic ack_cycle(input logic [2:0] mask, input logic rival,
		output logic [7:0] vec, output logic got, output logic drove);
		got = 1'b0;
		drove = 1'b0;
		vec = 8'h00;
		iack_mask_o = mask;
		iack_o = 1'b1;
		rival_o = rival;
		repeat (12)
		begin
			@(posedge core_clk_i);
			#1;
			if (arb_oe_i === 1'b1)
				drove = 1'b1;
			if (vec_oe_i === 1'b1 && got === 1'b0)
			begin
				got = 1'b1;
				vec = vec_i;
			end
		end
		iack_o = 1'b0;
		rival_o = 1'b0;
		iack_mask_o = ~mask;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
endmodule

// ### bench/tb_serial_global_ctl.sv
// testbench of the serial module global control block
`timescale 1ns/10ps
module tb_serial_global_ctl;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic freeze_i = 1'b0;
	logic sync_boundary_i = 1'b0;
	logic sync_irq_i = 1'b0;
	logic async_irq_i = 1'b0;
	logic ce = 1'b1;
	logic [1:0] reg_addr, reg_be;
	logic reg_wr, reg_rd, reg_ack, iack, rival, arb_o, arb_oe, vec_oe;
	logic clk_en, ram_en, halt, arb_line;
	logic [15:0] reg_wdata, reg_rdata, rd;
	logic [2:0] mask;
	logic [7:1] irq_lines;
	logic [7:0] vec_o, vec;
	logic got, drove;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;

	always #12.5 core_clk_i = ~core_clk_i;
	assign arb_line = (arb_oe & arb_o) | rival;

	serial_global_ctl i_serial_global_ctl (.core_clk_i(core_clk_i),
		.rst_i(rst_i), .ce_i(ce), .reg_addr_i(reg_addr),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_be_i(reg_be),
		.reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
		.reg_ack_o(reg_ack), .module_clk_en_o(clk_en),
		.ram_read_en_o(ram_en), .freeze_i(freeze_i),
		.sync_boundary_i(sync_boundary_i), .sync_halt_o(halt),
		.sync_irq_i(sync_irq_i), .async_irq_i(async_irq_i),
		.irq_lines_o(irq_lines), .iack_i(iack), .iack_mask_i(mask),
		.arb_line_i(arb_line), .arb_line_o(arb_o),
		.arb_line_oe_o(arb_oe), .vec_o(vec_o), .vec_oe_o(vec_oe));

	core_bus_model i_core_bus_model (.core_clk_i(core_clk_i),
		.reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_be_o(reg_be), .reg_wdata_o(reg_wdata),
		.reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack), .iack_o(iack),
		.iack_mask_o(mask), .rival_o(rival), .arb_oe_i(arb_oe),
		.vec_i(vec_o), .vec_oe_i(vec_oe));

	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e,
		input string msg);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, g, e);
		end
	endtask

	task automatic rw(input logic wr, input logic [1:0] a,
		input logic [1:0] be, input logic [15:0] wd, input logic [15:0] e);
		logic ack;
		i_core_bus_model.access(wr, a, be, wd, rd, ack);
		chk(16'(ack), 16'h0001, "ack");
		if (wr === 1'b0)
			chk(rd, e, "read data");
	endtask

	task automatic iack_chk(input logic [2:0] m, input logic r,
		input logic eg, input logic ed, input logic [7:0] ev);
		i_core_bus_model.ack_cycle(m, r, vec, got, drove);
		chk(16'(got), 16'(eg), "vector driven");
		chk(16'(drove), 16'(ed), "arbitration drive");
		if (eg === 1'b1)
			chk(16'(vec), 16'(ev), "vector value");
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			$display("CHECK FAILED %0t run timed out", $time);
			stop_test();
		end
	end

	initial
	begin
		repeat (6) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		// ------------------------------------------------------------
		// registers and stop
		// ------------------------------------------------------------
		rw(1'b0, 2'h0, 2'h3, 16'h0000, 16'h8000);
		chk(16'(clk_en), 16'h0000, "clock gated");
		chk(16'(ram_en), 16'h0000, "ram read");
		rw(1'b0, 2'h1, 2'h3, 16'h0000, 16'h0000);
		rw(1'b1, 2'h0, 2'h3, 16'h000A, 16'h0000);
		chk(16'(clk_en), 16'h0001, "clock running");
		rw(1'b0, 2'h1, 2'h3, 16'h0000, 16'h000F);
		rw(1'b1, 2'h3, 2'h3, 16'hFFFF, 16'h0000);
		rw(1'b0, 2'h2, 2'h3, 16'h0000, 16'h0000);
		rw(1'b1, 2'h0, 2'h2, 16'h8000, 16'h0000);
		rw(1'b1, 2'h1, 2'h3, 16'hEB52, 16'h0000);
		rw(1'b1, 2'h0, 2'h3, 16'hFFFF, 16'h0000);
		rw(1'b0, 2'h0, 2'h3, 16'h0000, 16'hE00F);
		rw(1'b0, 2'h1, 2'h3, 16'h0000, 16'h0000);
		rw(1'b1, 2'h0, 2'h3, 16'h400A, 16'h0000);
		rw(1'b0, 2'h1, 2'h3, 16'h0000, 16'h2B53);
		$display("test registers done");
		// ------------------------------------------------------------
		// request lines
		// ------------------------------------------------------------
		for (int l = 1; l < 8; l++)
		begin
			rw(1'b1, 2'h1, 2'h2, 16'(l) << 11, 16'h0000);
			sync_irq_i = 1'b1;
			async_irq_i = 1'b1;
			settle();
			chk(16'(irq_lines), 16'h0001 << (l - 1), "line");
		end
		rw(1'b1, 2'h1, 2'h2, 16'h2B00, 16'h0000);
		settle();
		chk(16'(irq_lines), 16'h0014, "two lines");
		repeat (5) @(posedge core_clk_i);
		#1;
		chk(16'(irq_lines), 16'h0014, "held");
		// enable low freezes the request lines
		ce = 1'b0;
		sync_irq_i = 1'b0;
		settle();
		chk(16'(irq_lines), 16'h0014, "frozen");
		ce = 1'b1;
		settle();
		chk(16'(irq_lines), 16'h0004, "async only");
		sync_irq_i = 1'b1;
		$display("test request lines done");
		// ------------------------------------------------------------
		// acknowledge and arbitration
		// ------------------------------------------------------------
		rw(1'b1, 2'h1, 2'h2, 16'h1B00, 16'h0000);
		settle();
		iack_chk(3'h3, 1'b0, 1'b1, 1'b1, 8'h53);
		sync_irq_i = 1'b0;
		settle();
		iack_chk(3'h3, 1'b0, 1'b1, 1'b1, 8'h52);
		iack_chk(3'h2, 1'b0, 1'b0, 1'b0, 8'h00);
		iack_chk(3'h3, 1'b1, 1'b0, 1'b1, 8'h00);
		rw(1'b1, 2'h0, 2'h3, 16'h4000, 16'h0000);
		iack_chk(3'h3, 1'b0, 1'b0, 1'b0, 8'h00);
		$display("test acknowledge done");
		// ------------------------------------------------------------
		// freeze: {cfg, boundary, expected halt}
		// ------------------------------------------------------------
		for (int k = 0; k < 3; k++)
		begin
			rw(1'b1, 2'h0, 2'h3, (k == 1) ? 16'h200A : 16'h400A,
				16'h0000);
			freeze_i = 1'b1;
			sync_boundary_i = (k != 2);
			settle();
			chk(16'(halt), (k == 0) ? 16'h0001 : 16'h0000, "halt");
			freeze_i = 1'b0;
			sync_boundary_i = 1'b0;
			settle();
			chk(16'(halt), 16'h0000, "halt released");
		end
		$display("test freeze done");
		// ------------------------------------------------------------
		// orderly stop
		// ------------------------------------------------------------
		async_irq_i = 1'b0;
		rw(1'b1, 2'h0, 2'h2, 16'h8000, 16'h0000);
		chk(16'(clk_en), 16'h0000, "stopped");
		chk(16'(ram_en), 16'h0000, "ram blocked");
		$display("test stop done");
		stop_test();
	end
endmodule
